// ---- src/poi_path_overhead_interrupt_regs.sv ----
// Interrupt status and enable registers of the receive path overhead processor.
// Assumes detector signals come from other clock domains and are synchronised here.
`timescale 1ns/1ps
module poi_path_overhead_interrupt_regs
	import poi_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	input  wire logic [POI_ADDR_W-1:0] i_avs_address,
	input  wire logic                  i_avs_read,
	input  wire logic                  i_avs_write,
	input  wire logic [POI_DATA_W-1:0] i_avs_writedata,
	input  wire logic [3:0]            i_avs_byteenable,
	output logic      [POI_DATA_W-1:0] o_avs_readdata,
	output logic      [1:0]            o_avs_response,
	output logic                       o_avs_waitrequest,
	input  wire poi_path_s             i_path,
	input  wire poi_ptr_s              i_ptr,
	output logic                       o_interrupt_out_n
);
	poi_path_s                 path_s1_reg;
	poi_path_s                 path_s2_reg;
	poi_path_s                 path_prev_reg;
	poi_ptr_s                  ptr_s1_reg;
	poi_ptr_s                  ptr_s2_reg;
	poi_ptr_s                  ptr_prev_reg;
	logic                      prev_valid_reg;
	logic [POI_REG_W-1:0]      alarm_stat_reg;
	logic [POI_REG_W-1:0]      enh_stat_reg;
	logic [POI_REG_W-1:0]      ptr_stat_reg;
	logic [POI_REG_W-1:0]      alarm_en_reg;
	logic [POI_REG_W-1:0]      enh_en_reg;
	logic [POI_REG_W-1:0]      ptr_en_reg;
	logic                      shadow_map_select_reg;
	poi_bus_e                  bus_state_reg;
	logic [POI_DATA_W-1:0]     readdata_reg;
	logic [1:0]                response_reg;
	logic                      irq_n_reg;
	logic [POI_REG_W-1:0]      alarm_evt;
	logic [POI_REG_W-1:0]      enh_evt;
	logic [POI_REG_W-1:0]      ptr_evt;
	logic                      access_done;
	logic                      rd_alarm;
	logic                      rd_enh;
	logic                      rd_ptr;
	logic                      wr_lane0;
	logic [POI_REG_W-1:0]      rd_seen;

	// Rising-edge detect of a synchronised level, gated until history is valid
	function automatic logic rise(input logic now, input logic was, input logic ok);
		rise = ok & now & ~was;
	endfunction

	function automatic logic bad_ndf(input logic [3:0] code);
		bad_ndf = (code == POI_NDF_BAD0) || (code == POI_NDF_BAD1) || (code == POI_NDF_BAD2) ||
			(code == POI_NDF_BAD3) || (code == POI_NDF_BAD4) || (code == POI_NDF_BAD5);
	endfunction

	// Two-flop synchronisers; the first stage feeds only the second
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			path_s1_reg <= '0;
			path_s2_reg <= '0;
			ptr_s1_reg  <= '0;
			ptr_s2_reg  <= '0;
		end else begin
			path_s1_reg <= i_path;
			path_s2_reg <= path_s1_reg;
			ptr_s1_reg  <= i_ptr;
			ptr_s2_reg  <= ptr_s1_reg;
		end
	end

	// History for edge and change detection; first sample after reset arms it only, but history
	// starts from the synchronisers' reset zeros, so a level already high at reset still raises a change flag
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			path_prev_reg  <= '0;
			ptr_prev_reg   <= '0;
			prev_valid_reg <= 1'b0;
		end else begin
			path_prev_reg  <= path_s2_reg;
			ptr_prev_reg   <= ptr_s2_reg;
			prev_valid_reg <= 1'b1;
		end
	end

	// Event decode; pulse inputs are treated as levels and edge-detected
	always_comb begin
		alarm_evt = '0;
		enh_evt   = '0;
		ptr_evt   = '0;
		alarm_evt[POI_B_FAR_END] = rise(path_s2_reg.far_end_err, path_prev_reg.far_end_err, prev_valid_reg);
		alarm_evt[POI_B_PARITY]  = rise(path_s2_reg.parity_err, path_prev_reg.parity_err, prev_valid_reg);
		alarm_evt[POI_B_REMOTE]  = prev_valid_reg &
			((path_s2_reg.rdi_state != path_prev_reg.rdi_state) ||
			(path_s2_reg.aux_rdi_state != path_prev_reg.aux_rdi_state));
		alarm_evt[POI_B_AIS]     = prev_valid_reg & (path_s2_reg.ais_state != path_prev_reg.ais_state);
		alarm_evt[POI_B_LOP]     = prev_valid_reg & (path_s2_reg.lop_state != path_prev_reg.lop_state);
		alarm_evt[POI_B_LABEL]   = prev_valid_reg & (path_s2_reg.label != path_prev_reg.label);
		enh_evt[POI_B_ENH_RDI]   = prev_valid_reg &
			(path_s2_reg.enh_rdi_state != path_prev_reg.enh_rdi_state);
		ptr_evt[0] = rise(ptr_s2_reg.ndf_active, ptr_prev_reg.ndf_active, prev_valid_reg);
		ptr_evt[1] = rise(ptr_s2_reg.pos_stuff, ptr_prev_reg.pos_stuff, prev_valid_reg);
		ptr_evt[2] = rise(ptr_s2_reg.neg_stuff, ptr_prev_reg.neg_stuff, prev_valid_reg);
		ptr_evt[3] = rise(ptr_s2_reg.bad_pointer, ptr_prev_reg.bad_pointer, prev_valid_reg);
		// Code is sampled with its strobe; code and strobe cross together
		ptr_evt[4] = rise(ptr_s2_reg.ndf_valid, ptr_prev_reg.ndf_valid, prev_valid_reg) &
			bad_ndf(ptr_s2_reg.ndf_code);
		ptr_evt[5] = rise(ptr_s2_reg.new_ptr_no_ndf, ptr_prev_reg.new_ptr_no_ndf, prev_valid_reg);
		ptr_evt[7] = rise(ptr_s2_reg.bad_justify, ptr_prev_reg.bad_justify, prev_valid_reg);
	end

	// Bus access: every request answers in the cycle after it is taken
	assign access_done = (bus_state_reg == POI_ANSWER);
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~access_done;
	assign rd_alarm = access_done & i_avs_read & (i_avs_address == POI_IDX_ALARM_STAT) & ~shadow_map_select_reg;
	assign rd_enh   = access_done & i_avs_read & (i_avs_address == POI_IDX_ALARM_STAT) & shadow_map_select_reg;
	assign rd_ptr   = access_done & i_avs_read & (i_avs_address == POI_IDX_PTR_STAT);
	assign wr_lane0 = access_done & i_avs_write & i_avs_byteenable[0];
	// Status value captured at the take edge; only these bits may be cleared
	assign rd_seen  = readdata_reg[POI_REG_W-1:0];

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus_state_reg <= POI_IDLE;
		end else begin
			case (bus_state_reg)
				POI_IDLE:   bus_state_reg <= (i_avs_read | i_avs_write) ? POI_ANSWER : POI_IDLE;
				POI_ANSWER: bus_state_reg <= POI_IDLE;
				default:    bus_state_reg <= POI_IDLE;
			endcase
		end
	end

	// Sticky flags: a coincident event wins over the clearing read, and a flag set
	// between the take edge and the answer edge was not reported, so it is kept
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			alarm_stat_reg <= POI_RESET_VAL;
			enh_stat_reg   <= POI_RESET_VAL;
			ptr_stat_reg   <= POI_RESET_VAL;
		end else begin
			alarm_stat_reg <= ((alarm_stat_reg & ~(rd_alarm ? rd_seen : POI_RESET_VAL)) | alarm_evt) &
				POI_ALARM_IMPL;
			enh_stat_reg   <= ((enh_stat_reg & ~(rd_enh ? rd_seen : POI_RESET_VAL)) | enh_evt) &
				POI_ENH_MASK;
			ptr_stat_reg   <= ((ptr_stat_reg & ~(rd_ptr ? rd_seen : POI_RESET_VAL)) | ptr_evt) &
				POI_PTR_MASK;
		end
	end

	// Enable and control registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			alarm_en_reg          <= POI_RESET_VAL;
			enh_en_reg            <= POI_RESET_VAL;
			ptr_en_reg            <= POI_RESET_VAL;
			shadow_map_select_reg <= 1'b0;
		end else if (wr_lane0) begin
			if (i_avs_address == POI_IDX_ALARM_EN) begin
				if (shadow_map_select_reg) begin
					enh_en_reg <= i_avs_writedata[POI_REG_W-1:0] & POI_ENH_MASK;
				end else begin
					// Reserved bit 6 is cleared by POI_ALARM_MASK, whatever software writes
					alarm_en_reg <= i_avs_writedata[POI_REG_W-1:0] & POI_ALARM_MASK;
				end
			end
			if (i_avs_address == POI_IDX_PTR_EN) begin
				ptr_en_reg <= i_avs_writedata[POI_REG_W-1:0] & POI_PTR_MASK;
			end
			if (i_avs_address == POI_IDX_PTR_MSB) begin
				shadow_map_select_reg <= i_avs_writedata[POI_B_SHADOW_SEL];
			end
		end
	end

	// Read data and response, registered at the take edge
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			readdata_reg <= '0;
			response_reg <= 2'h0;
		end else if ((bus_state_reg == POI_IDLE) && (i_avs_read | i_avs_write)) begin
			readdata_reg <= '0;
			response_reg <= 2'h0;
			case (i_avs_address)
				POI_IDX_ALARM_STAT: readdata_reg[POI_REG_W-1:0] <=
					shadow_map_select_reg ? enh_stat_reg : alarm_stat_reg;
				POI_IDX_PTR_STAT:   readdata_reg[POI_REG_W-1:0] <= ptr_stat_reg;
				POI_IDX_ALARM_EN:   readdata_reg[POI_REG_W-1:0] <=
					shadow_map_select_reg ? enh_en_reg : alarm_en_reg;
				POI_IDX_PTR_EN:     readdata_reg[POI_REG_W-1:0] <= ptr_en_reg;
				POI_IDX_PTR_MSB:    readdata_reg[POI_B_SHADOW_SEL] <= shadow_map_select_reg;
				default:            response_reg <= 2'h2;
			endcase
		end
	end

	assign o_avs_readdata = readdata_reg;
	assign o_avs_response = response_reg;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= ~(|(alarm_stat_reg & alarm_en_reg) | |(enh_stat_reg & enh_en_reg) |
				|(ptr_stat_reg & ptr_en_reg));
		end
	end

	assign o_interrupt_out_n = irq_n_reg;
endmodule

// ---- src/poi_pkg.sv ----
// Package for the receive path overhead interrupt register block.
// Assumes an 8-bit register space mapped one register per 32-bit Avalon word.
package poi_pkg;
	localparam int          POI_ADDR_W          = 8;
	localparam int          POI_DATA_W          = 32;
	localparam int          POI_REG_W           = 8;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  POI_IDX_ALARM_STAT  = 8'h31;
	localparam logic [7:0]  POI_IDX_PTR_STAT    = 8'h32;
	localparam logic [7:0]  POI_IDX_ALARM_EN    = 8'h33;
	localparam logic [7:0]  POI_IDX_PTR_EN      = 8'h34;
	localparam logic [7:0]  POI_IDX_PTR_MSB     = 8'h36;
	// Path alarm bit positions, then enhanced RDI and shadow select bits
	localparam int          POI_B_FAR_END       = 0;
	localparam int          POI_B_PARITY        = 1;
	localparam int          POI_B_REMOTE        = 2;
	localparam int          POI_B_AIS           = 3;
	localparam int          POI_B_LOP           = 5;
	localparam int          POI_B_LABEL         = 7;
	localparam int          POI_B_ENH_RDI       = 0;
	localparam int          POI_B_SHADOW_SEL    = 6;
	// Writable bit masks, implemented alarm status bits and reset value
	localparam logic [7:0]  POI_ALARM_MASK      = 8'hbf;
	localparam logic [7:0]  POI_ALARM_IMPL      = 8'haf;
	localparam logic [7:0]  POI_ENH_MASK        = 8'h01;
	localparam logic [7:0]  POI_PTR_MASK        = 8'hbf;
	localparam logic [7:0]  POI_MSB_MASK        = 8'h40;
	localparam logic [7:0]  POI_RESET_VAL       = 8'h00;
	// Invalid new-data-flag codes
	localparam logic [3:0]  POI_NDF_BAD0        = 4'h0;
	localparam logic [3:0]  POI_NDF_BAD1        = 4'h3;
	localparam logic [3:0]  POI_NDF_BAD2        = 4'h5;
	localparam logic [3:0]  POI_NDF_BAD3        = 4'ha;
	localparam logic [3:0]  POI_NDF_BAD4        = 4'hc;
	localparam logic [3:0]  POI_NDF_BAD5        = 4'hf;

	// Error pulses and state levels from the path detectors
	typedef struct packed {
		logic       far_end_err;
		logic       parity_err;
		logic       rdi_state;
		logic       aux_rdi_state;
		logic       ais_state;
		logic       lop_state;
		logic [7:0] label;
		logic [2:0] enh_rdi_state;
	} poi_path_s;

	typedef struct packed {
		logic       ndf_active;
		logic       pos_stuff;
		logic       neg_stuff;
		logic       bad_pointer;
		logic       ndf_valid;
		logic [3:0] ndf_code;
		logic       new_ptr_no_ndf;
		logic       bad_justify;
	} poi_ptr_s;

	typedef enum logic [1:0] {
		POI_IDLE,
		POI_ANSWER
	} poi_bus_e;
endpackage

// ---- tb/poi_assertions.sv ----
// Port-level checks for the path overhead interrupt register block.
// Assumes one wait cycle per Avalon request and an active low interrupt.
`timescale 1ns/1ps
module poi_assertions
	import poi_pkg::*;
(
	input wire logic                  i_clk,
	input wire logic                  i_arst_n,
	input wire logic [POI_ADDR_W-1:0] i_avs_address,
	input wire logic                  i_avs_read,
	input wire logic                  i_avs_write,
	input wire logic [POI_DATA_W-1:0] o_avs_readdata,
	input wire logic [1:0]            o_avs_response,
	input wire logic                  o_avs_waitrequest,
	input wire logic                  o_interrupt_out_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	logic req;
	logic mapped;
	assign req    = i_avs_read || i_avs_write;
	assign mapped = i_avs_address inside {POI_IDX_ALARM_STAT, POI_IDX_PTR_STAT, POI_IDX_ALARM_EN,
		POI_IDX_PTR_EN, POI_IDX_PTR_MSB};
	sequence s_wait; req && o_avs_waitrequest; endsequence
	sequence s_done; req && !o_avs_waitrequest; endsequence
	property p_one_wait; s_wait |=> s_done; endproperty
	property p_one_answer; s_done |=> !req || o_avs_waitrequest; endproperty
	property p_idle; !req |-> !o_avs_waitrequest; endproperty
	property p_unmapped; s_done ##0 !mapped |-> o_avs_response == 2'h2 && o_avs_readdata == 32'h0; endproperty
	property p_mapped; s_done ##0 mapped |-> o_avs_response == 2'h0; endproperty
	property p_pad; s_done ##0 i_avs_read |-> o_avs_readdata[31:8] == 24'h0; endproperty
	property p_int_rise; $rose(o_interrupt_out_n) |-> $past(req && !o_avs_waitrequest, 2); endproperty
	property p_reset_quiet; $rose(i_arst_n) |-> o_interrupt_out_n [*4]; endproperty
	a_one_wait: assert property (p_one_wait) else $error("request not answered after one wait");
	a_one_answer: assert property (p_one_answer) else $error("answer lasted more than one cycle");
	a_idle: assert property (p_idle) else $error("waitrequest high without request");
	a_unmapped: assert property (p_unmapped) else $error("unmapped index not refused");
	a_mapped: assert property (p_mapped) else $error("mapped index refused");
	a_pad: assert property (p_pad) else $error("upper read data not zero");
	a_int_rise: assert property (p_int_rise) else $error("interrupt released without access");
	a_reset_quiet: assert property (p_reset_quiet) else $error("interrupt active after reset");
endmodule

// ---- tb/poi_path_overhead_interrupt_regs_test.sv ----
// Self-checking bench for the path overhead interrupt register block.
// Assumes event inputs are held several cycles so the input synchronisers see them.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module poi_path_overhead_interrupt_regs_test
	import poi_pkg::*;
;
	logic        i_clk = 1'b0, i_arst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic [7:0]  i_avs_address = 8'h00, en, x;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
	logic [3:0]  i_avs_byteenable = 4'h1, c;
	logic [1:0]  o_avs_response;
	logic        o_avs_waitrequest, o_interrupt_out_n;
	logic [10:0] q;
	poi_path_s   i_path = '0;
	poi_ptr_s    i_ptr = '0;
	int          n_mismatch = 0, n_compared = 0, cyc = 0;
	logic [16:0] ptab[7] = '{17'h10000, 17'h08000, 17'h04000, 17'h02000, 17'h01000, 17'h00800, 17'h000a8};
	logic [7:0]  pexp[7] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h20, 8'h80};
	logic [10:0] qtab[6] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h002, 11'h001};
	logic [7:0]  qexp[6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h80};
	poi_path_overhead_interrupt_regs i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_response(o_avs_response),
		.o_avs_waitrequest(o_avs_waitrequest), .i_path(i_path), .i_ptr(i_ptr),
		.o_interrupt_out_n(o_interrupt_out_n));
	always #5 i_clk = ~i_clk;
	task automatic end_of_test();
		if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b,
		input logic [7:0] e);
		i_avs_address    <= a;
		i_avs_write      <= w;
		i_avs_read       <= !w;
		i_avs_writedata  <= {24'h0, d};
		i_avs_byteenable <= b;
		do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
		if (!w) `CHK(o_avs_readdata, {24'h0, e})
		`CHK(o_avs_response, (a inside {8'h31, 8'h32, 8'h33, 8'h34, 8'h36}) ? 2'h0 : 2'h2)
		i_avs_read  <= 1'b0;
		i_avs_write <= 1'b0;
		@(posedge i_clk);
	endtask
	// Each event goes away again, so level fields return to idle between cases
	task automatic ev(input logic [16:0] p, input logic [10:0] r);
		i_path <= p;
		i_ptr  <= r;
		repeat (6) @(posedge i_clk);
		i_path <= '0;
		i_ptr  <= '0;
		repeat (6) @(posedge i_clk);
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		for (int i = 8'h31; i < 8'h37; i++) acc(1'b0, i[7:0], 8'h00, 4'h1, 8'h00);
		acc(1'b1, 8'h32, 8'hff, 4'h1, 8'h00);
		acc(1'b1, 8'h35, 8'hff, 4'h1, 8'h00);
		acc(1'b0, 8'h32, 8'h00, 4'h1, 8'h00);
		for (int k = 0; k < 2; k++) begin
			en = k ? 8'hff : 8'h00;
			acc(1'b1, 8'h33, en & 8'haf, 4'h1, 8'h00);
			acc(1'b1, 8'h34, en & 8'hbf, 4'h1, 8'h00);
			acc(1'b0, 8'h33, 8'h00, 4'h1, en & 8'haf);
			acc(1'b0, 8'h34, 8'h00, 4'h1, en & 8'hbf);
			for (int i = 0; i < 7; i++) begin
				ev(ptab[i], '0);
				`CHK(o_interrupt_out_n, ~en[0])
				acc(1'b0, 8'h31, 8'h00, 4'h1, pexp[i]);
				acc(1'b0, 8'h31, 8'h00, 4'h1, 8'h00);
				`CHK(o_interrupt_out_n, 1'b1)
			end
			for (int i = 0; i < 22; i++) begin
				c = 4'(i - 6);
				q = i < 6 ? qtab[i] : {5'h01, c, 2'h0};
				x = i < 6 ? qexp[i] : ((c inside {4'h0, 4'h3, 4'h5, 4'ha, 4'hc, 4'hf}) ? 8'h10 : 8'h00);
				ev('0, q);
				`CHK(o_interrupt_out_n, ~(en[0] & (|x)))
				acc(1'b0, 8'h32, 8'h00, 4'h1, x);
				acc(1'b0, 8'h32, 8'h00, 4'h1, 8'h00);
			end
		end
		// Event lands on the clearing read's answer edge, then on its take edge
		for (int j = 1; j < 3; j++) begin
			i_path <= 17'h10000;
			repeat (j) @(posedge i_clk);
			acc(1'b0, 8'h31, 8'h00, 4'h1, 8'h00);
			acc(1'b0, 8'h31, 8'h00, 4'h1, 8'h01);
			i_path <= '0;
			repeat (6) @(posedge i_clk);
		end
		acc(1'b1, 8'h36, 8'hff, 4'h1, 8'h00);
		acc(1'b0, 8'h36, 8'h00, 4'h1, 8'h40);
		acc(1'b0, 8'h33, 8'h00, 4'h1, 8'h00);
		acc(1'b1, 8'h33, 8'h01, 4'h1, 8'h00);
		acc(1'b0, 8'h31, 8'h00, 4'h1, 8'h00);
		ev(17'h00005, '0);
		`CHK(o_interrupt_out_n, 1'b0)
		acc(1'b0, 8'h31, 8'h00, 4'h1, 8'h01);
		acc(1'b0, 8'h31, 8'h00, 4'h1, 8'h00);
		`CHK(o_interrupt_out_n, 1'b1)
		acc(1'b1, 8'h36, 8'h00, 4'h1, 8'h00);
		acc(1'b1, 8'h33, 8'h00, 4'h0, 8'h00);
		acc(1'b0, 8'h33, 8'h00, 4'h1, 8'haf);
		end_of_test();
	end
endmodule
bind poi_path_overhead_interrupt_regs poi_assertions i_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata), .o_avs_response(o_avs_response), .o_avs_waitrequest(o_avs_waitrequest),
	.o_interrupt_out_n(o_interrupt_out_n));
